/* File: hdl/audio_cfg_pkg.sv */
// Purpose: constants for the audio path configuration register
// Assumes: 16-bit control link words, 7-bit register index
// Notes:   limiter figures are counted in output samples
package audio_cfg_pkg;
	localparam logic [6:0]  CFG_ADDR     = 7'h5A;
	localparam logic [15:0] CFG_RESET    = 16'h1170;
	// Only the compliance bit is defined in full compliance mode
	localparam logic [15:0] FC_READ_MASK = 16'h0001;
	localparam int BIT_FC    = 0;
	localparam int BIT_DBUF  = 1;
	localparam int BIT_GAIN0 = 2;
	localparam int BIT_GAIN1 = 3;
	localparam int BIT_ORST  = 4;
	localparam int BIT_ZDEN  = 5;
	localparam int BIT_TT    = 6;
	localparam int BIT_MULT  = 7;
	localparam int BIT_MBYP  = 8;
	localparam int BIT_MCKO  = 9;
	localparam int BIT_SRCS  = 10;
	localparam int BIT_SPDM  = 11;
	localparam int BIT_THR0  = 12;
	localparam int BIT_THR1  = 13;
	localparam int BIT_DBG   = 14;
	localparam int BIT_RBYP  = 15;
	// Anti-alias windows in Hz
	localparam logic [16:0] AA1_LO = 17'hE5FB;
	localparam logic [16:0] AA1_HI = 17'hEEC5;
	localparam logic [16:0] AA2_LO = 17'h1347D;
	localparam logic [16:0] AA2_HI = 17'h13C68;
	// Seven limiter constants and the zero-run length, thresholds in 1/256 of full scale
	localparam int          LIM_HI_FRAC     = 248;
	localparam int          LIM_LO_FRAC     = 192;
	localparam logic [7:0]  ATTACK_STEP     = 8'h04;
	localparam logic [11:0] ATTACK_SAMPLES  = 12'h002;
	localparam logic [7:0]  RELEASE_STEP    = 8'h01;
	localparam logic [11:0] RELEASE_SAMPLES = 12'h010;
	localparam logic [11:0] RELEASE_HOLD    = 12'h0F0;
	localparam logic [9:0]  ZERO_RUN        = 10'h200;
	typedef enum logic [3:0] {
		LIM_IDLE    = 4'b0001,
		LIM_ATTACK  = 4'b0010,
		LIM_HOLD    = 4'b0100,
		LIM_RELEASE = 4'b1000
	} lim_state_t;
endpackage

/* File: hdl/audio_path_config_reg.sv */
// Purpose: configuration register and the audio path steering it
// Assumes: register port and audio strobes come from logic on clk
// Notes:   clock selects are levels for the clock generator
//
// Overview of operation
// - With compliance bit 0, reads return only defined bits, others zero.
// - Double-buffer bit 1 holds serial words until the frame tick.
// - Gain bits select 1x, 2x, 2x compressed or 3x compressed.
// - Output-stage reset bit, active high, holds output stage; resets to 1.
// - Zero-detect works while its bit is 1; resets to 1.
// - Truth-table bit selects output table, 1 is standard; resets to 1.
// - Multiplier-bypass bit 0 feeds master clock from crystal input.
// - Clock-out bit selects 12.288 MHz when 1, 24.576 MHz when 0.
// - Source bit routes serial input at 0, S/PDIF at 1.
// - S/PDIF mode bit selects analog at 0, digital at 1.
// - Threshold bits: never, 58.875-61.125kHz, 78.973-81.000kHz, always.
// - Ratio-debug bit puts the loop ratio on output channels.
// - Resampler-bypass bit feeds selected input straight to the processor.
// - Without compression, output above full scale is clipped.
// - Compression reduces gain in steps above a threshold near full scale.
// - Below a lower threshold for a hold time, gain is raised again.
// - Seven fixed constants shape attack, release and limiting.
`timescale 1ns/1ns
module audio_path_config_reg
	import audio_cfg_pkg::*;
#(
	parameter int SAMPLE_W = 20
) (
	input  wire logic                clk,
	input  wire logic                srst,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	input  wire logic [6:0]          reg_addr,
	input  wire logic [15:0]         reg_wdata,
	output logic      [15:0]         reg_rdata,
	output logic                     reg_ack,
	input  wire logic                serial_valid,
	input  wire logic [SAMPLE_W-1:0] serial_sample,
	input  wire logic                spdif_valid,
	input  wire logic [SAMPLE_W-1:0] spdif_sample,
	input  wire logic                frame_tick,
	output logic                     resampler_in_valid,
	output logic      [SAMPLE_W-1:0] resampler_in_sample,
	input  wire logic                resampler_out_valid,
	input  wire logic [SAMPLE_W-1:0] resampler_out_sample,
	output logic                     proc_in_valid,
	output logic      [SAMPLE_W-1:0] proc_in_sample,
	input  wire logic [16:0]         input_rate_hz,
	output logic                     antialias_enable,
	input  wire logic                vol_valid,
	input  wire logic [SAMPLE_W-1:0] vol_sample,
	input  wire logic [SAMPLE_W-1:0] ratio_value,
	output logic                     out_valid,
	output logic      [SAMPLE_W-1:0] out_sample,
	output logic                     zero_detected,
	output logic      [7:0]          gain_reduction,
	output logic                     output_stage_reset,
	output logic                     truth_table_standard,
	output logic                     spdif_digital_mode,
	output logic                     multiplier_x8,
	output logic                     master_clock_from_crystal,
	output logic                     master_clock_out_12m288
);
	localparam int XW = SAMPLE_W + 3;
	localparam int PW = XW + 10;
	localparam int FS = (1 << (SAMPLE_W - 1)) - 1;
	localparam logic [XW-1:0] FS_POS = XW'(FS);
	localparam logic [XW-1:0] FS_NEG = XW'(-FS - 1);
	localparam logic [XW-1:0] THR_HI = XW'(FS / 256 * LIM_HI_FRAC);
	localparam logic [XW-1:0] THR_LO = XW'(FS / 256 * LIM_LO_FRAC);

	initial begin
		if (SAMPLE_W < 16 || SAMPLE_W > 24)
			$error("SAMPLE_W must lie in 16..24");
	end

	logic [15:0]          cfg_r;
	logic                 hit;
	logic                 comp;
	logic [1:0]           gain_code;
	logic [SAMPLE_W-1:0]  ser_stage_r;
	logic                 ser_full_r;
	logic [SAMPLE_W-1:0]  ser_word_r;
	logic                 ser_valid_r;
	logic                 sel_valid;
	logic [SAMPLE_W-1:0]  sel_sample;
	logic signed [XW-1:0] vol_ext;
	logic signed [XW-1:0] gained;
	logic signed [PW-1:0] prod;
	logic signed [XW-1:0] pre;
	logic signed [XW-1:0] clipped;
	logic [XW-1:0]        mag;
	logic [7:0]           gr_r;
	lim_state_t           lim_r;
	logic [11:0]          lim_cnt_r;
	logic [9:0]           zero_cnt_r;

	assign hit       = reg_addr == CFG_ADDR;
	assign gain_code = {cfg_r[BIT_GAIN0], cfg_r[BIT_GAIN1]};
	assign comp      = cfg_r[BIT_GAIN0];

	always_ff @(posedge clk) begin
		if (srst)
			cfg_r <= CFG_RESET;
		else if (reg_wr && hit)
			cfg_r <= reg_wdata;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= 16'h0000;
			reg_ack   <= 1'b0;
		end else begin
			reg_ack <= (reg_rd || reg_wr) && hit;
			if (reg_rd && hit)
				reg_rdata <= cfg_r[BIT_FC] ? cfg_r
					: (cfg_r & FC_READ_MASK);
			else if (reg_rd)
				reg_rdata <= 16'h0000;
		end
	end

	assign output_stage_reset        = cfg_r[BIT_ORST];
	assign truth_table_standard      = cfg_r[BIT_TT];
	assign spdif_digital_mode        = cfg_r[BIT_SPDM];
	// Host must match this to the reference rate
	assign multiplier_x8             = cfg_r[BIT_MULT];
	assign master_clock_from_crystal = !cfg_r[BIT_MBYP];
	assign master_clock_out_12m288   = cfg_r[BIT_MCKO];
	assign gain_reduction            = gr_r;

	// Staged word lets a slave source drift against the frame tick
	always_ff @(posedge clk) begin
		if (srst) begin
			ser_stage_r <= '0;
			ser_full_r  <= 1'b0;
			ser_word_r  <= '0;
			ser_valid_r <= 1'b0;
		end else if (cfg_r[BIT_DBUF]) begin
			ser_valid_r <= frame_tick && ser_full_r;
			if (frame_tick && ser_full_r)
				ser_word_r <= ser_stage_r;
			if (serial_valid) begin
				ser_stage_r <= serial_sample;
				ser_full_r  <= 1'b1;
			end else if (frame_tick)
				ser_full_r <= 1'b0;
		end else begin
			ser_full_r  <= 1'b0;
			ser_valid_r <= serial_valid;
			if (serial_valid)
				ser_word_r <= serial_sample;
		end
	end

	always_comb begin
		if (cfg_r[BIT_SRCS]) begin
			sel_valid  = spdif_valid;
			sel_sample = spdif_sample;
		end else begin
			sel_valid  = ser_valid_r;
			sel_sample = ser_word_r;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			resampler_in_valid  <= 1'b0;
			resampler_in_sample <= '0;
			proc_in_valid       <= 1'b0;
			proc_in_sample      <= '0;
		end else begin
			resampler_in_valid <= sel_valid && !cfg_r[BIT_RBYP];
			if (sel_valid)
				resampler_in_sample <= sel_sample;
			if (cfg_r[BIT_RBYP]) begin
				proc_in_valid <= sel_valid;
				if (sel_valid)
					proc_in_sample <= sel_sample;
			end else begin
				proc_in_valid <= resampler_out_valid;
				if (resampler_out_valid)
					proc_in_sample <= resampler_out_sample;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			antialias_enable <= 1'b0;
		else begin
			unique case ({cfg_r[BIT_THR0], cfg_r[BIT_THR1]})
				2'b00: antialias_enable <= 1'b0;
				2'b01: antialias_enable <= input_rate_hz >= AA1_LO
					&& input_rate_hz <= AA1_HI;
				2'b10: antialias_enable <= input_rate_hz >= AA2_LO
					&& input_rate_hz <= AA2_HI;
				2'b11: antialias_enable <= 1'b1;
			endcase
		end
	end

	always_comb begin
		vol_ext = XW'($signed(vol_sample));
		unique case (gain_code)
			2'b00: gained = vol_ext;
			2'b01: gained = vol_ext <<< 1;
			2'b10: gained = vol_ext <<< 1;
			2'b11: gained = XW'(vol_ext + (vol_ext <<< 1));
		endcase
		prod = PW'(gained) * $signed({2'b00, 9'h100 - {1'b0, gr_r}});
		pre  = comp ? prod[XW+7:8] : gained;
		if (pre > $signed(FS_POS))
			clipped = FS_POS;
		else if (pre < $signed(FS_NEG))
			clipped = FS_NEG;
		else
			clipped = pre;
		mag = pre[XW-1] ? XW'(-pre) : pre;
	end

	// Limiter runs per sample; counts are in samples, not clocks
	always_ff @(posedge clk) begin
		if (srst || !comp || output_stage_reset) begin
			lim_r     <= LIM_IDLE;
			gr_r      <= 8'h00;
			lim_cnt_r <= 12'h000;
		end else if (vol_valid) begin
			unique case (lim_r)
				LIM_IDLE: begin
					lim_cnt_r <= 12'h000;
					if (mag > THR_HI)
						lim_r <= LIM_ATTACK;
				end
				LIM_ATTACK: begin
					if (mag <= THR_HI) begin
						lim_r     <= LIM_HOLD;
						lim_cnt_r <= 12'h000;
					end else if (lim_cnt_r == ATTACK_SAMPLES - 12'h001) begin
						lim_cnt_r <= 12'h000;
						gr_r <= (gr_r > 8'hFF - ATTACK_STEP) ? 8'hFF
							: gr_r + ATTACK_STEP;
					end else
						lim_cnt_r <= lim_cnt_r + 12'h001;
				end
				LIM_HOLD: begin
					if (mag > THR_HI) begin
						lim_r     <= LIM_ATTACK;
						lim_cnt_r <= 12'h000;
					end else if (mag >= THR_LO)
						lim_cnt_r <= 12'h000;
					else if (lim_cnt_r == RELEASE_HOLD - 12'h001) begin
						lim_r     <= LIM_RELEASE;
						lim_cnt_r <= 12'h000;
					end else
						lim_cnt_r <= lim_cnt_r + 12'h001;
				end
				LIM_RELEASE: begin
					if (mag > THR_HI) begin
						lim_r     <= LIM_ATTACK;
						lim_cnt_r <= 12'h000;
					end else if (mag >= THR_LO) begin
						lim_r     <= LIM_HOLD;
						lim_cnt_r <= 12'h000;
					end else if (lim_cnt_r == RELEASE_SAMPLES - 12'h001) begin
						lim_cnt_r <= 12'h000;
						gr_r <= (gr_r > RELEASE_STEP) ? gr_r - RELEASE_STEP
							: 8'h00;
						if (gr_r <= RELEASE_STEP)
							lim_r <= LIM_IDLE;
					end else
						lim_cnt_r <= lim_cnt_r + 12'h001;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			out_valid  <= 1'b0;
			out_sample <= '0;
		end else begin
			out_valid <= vol_valid;
			if (vol_valid) begin
				if (output_stage_reset)
					out_sample <= '0;
				else if (cfg_r[BIT_DBG])
					out_sample <= ratio_value;
				else
					out_sample <= clipped[SAMPLE_W-1:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst || !cfg_r[BIT_ZDEN]) begin
			zero_cnt_r    <= 10'h000;
			zero_detected <= 1'b0;
		end else if (out_valid) begin
			if (out_sample != '0) begin
				zero_cnt_r    <= 10'h000;
				zero_detected <= 1'b0;
			end else if (zero_cnt_r == ZERO_RUN - 10'h001)
				zero_detected <= 1'b1;
			else
				zero_cnt_r <= zero_cnt_r + 10'h001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_cfg_write;
		reg_wr && hit;
	endsequence
	sequence s_quiet_end;
		vol_valid && comp && !output_stage_reset && lim_r == LIM_HOLD
			&& mag < THR_LO && lim_cnt_r == RELEASE_HOLD - 12'h001;
	endsequence

	a_reset_value: assert property ($fell(srst) |-> cfg_r == CFG_RESET)
		else $error("register not at reset value");
	a_write_readback: assert property (s_cfg_write ##1 !reg_wr
		##1 (reg_rd && hit && !reg_wr && cfg_r[BIT_FC])
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("written value not read back");
	a_compliance_mask: assert property (reg_rd && hit && !cfg_r[BIT_FC]
		|=> (reg_rdata & ~FC_READ_MASK) == 16'h0000)
		else $error("undefined bits visible in compliance mode");
	a_dbuf_tick: assert property (cfg_r[BIT_DBUF] && $past(cfg_r[BIT_DBUF])
		&& ser_valid_r |-> $past(frame_tick))
		else $error("double buffer released off frame tick");
	a_gain_unity: assert property (vol_valid && gain_code == 2'b00
		&& !output_stage_reset && !cfg_r[BIT_DBG]
		|=> out_sample == $past(vol_sample))
		else $error("unity gain path altered sample");
	a_stage_reset: assert property (vol_valid && output_stage_reset
		|=> out_valid && out_sample == '0)
		else $error("output not held in reset");
	a_zero_off: assert property (!cfg_r[BIT_ZDEN] |=> !zero_detected)
		else $error("zero flag while disabled");
	a_source_route: assert property (spdif_valid && cfg_r[BIT_SRCS]
		&& !cfg_r[BIT_RBYP] |=> resampler_in_valid
		&& resampler_in_sample == $past(spdif_sample))
		else $error("S/PDIF word not routed");
	a_aa_never: assert property (!cfg_r[BIT_THR0] && !cfg_r[BIT_THR1]
		|=> !antialias_enable)
		else $error("anti-alias enabled in never mode");
	a_ratio_debug: assert property (vol_valid && cfg_r[BIT_DBG]
		&& !output_stage_reset |=> out_sample == $past(ratio_value))
		else $error("ratio not on output");
	a_bypass_route: assert property (sel_valid && cfg_r[BIT_RBYP]
		|=> proc_in_valid && proc_in_sample == $past(sel_sample))
		else $error("bypass did not feed processor");
	a_clip_level: assert property (vol_valid && !comp && !output_stage_reset
		&& !cfg_r[BIT_DBG] && gained > $signed(FS_POS)
		|=> out_sample == FS_POS[SAMPLE_W-1:0])
		else $error("overrange not clipped");
	a_attack_step: assert property (vol_valid && comp && !output_stage_reset
		&& lim_r == LIM_ATTACK && mag > THR_HI && gr_r < 8'hF0
		&& lim_cnt_r == ATTACK_SAMPLES - 12'h001
		|=> gr_r == $past(gr_r) + ATTACK_STEP)
		else $error("attack step missing");
	a_release_start: assert property (s_quiet_end
		|=> lim_r == LIM_RELEASE && gr_r == $past(gr_r))
		else $error("release not entered after hold");
endmodule // audio_path_config_reg

/* File: testbench/host_link_model.sv */
// Purpose: host controller driving the control link register port
// Assumes: one-cycle strobes, answer one cycle after the strobe
// Notes:   released address and data lines show inverted values, strobes drop to 0
`timescale 1ns/1ns
module host_link_model
	import audio_cfg_pkg::*;
(
	input  wire logic        clk,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [6:0]       reg_addr,
	output logic [15:0]      reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_ack
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 16'h0000;
	end
	task automatic access(input logic wr, input logic [6:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic ak);
		@(negedge clk);
		reg_wr = wr;
		reg_rd = !wr;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		// Ack stands one cycle only, so take it before the next edge
		ak = reg_ack;
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// Multiplier factor follows the reference the board supplies
	function automatic logic [15:0] clock_bits(input logic [15:0] v,
		input logic ref_6m144);
		return ref_6m144 ? v | 16'h0080 : v & 16'hFF7F;
	endfunction
endmodule // host_link_model

/* File: testbench/audio_path_config_reg_test.sv */
// Purpose: self-checking bench for the audio path configuration register
// Assumes: host model owns the register port; bench drives audio strobes
// Notes:   pseudo-random values from a fixed-seed shift register
`timescale 1ns/1ns
module audio_path_config_reg_test
	import audio_cfg_pkg::*;
;
	logic        clk, srst, reg_wr, reg_rd, reg_ack, ak;
	logic [6:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, q, v;
	logic        serial_valid, spdif_valid, frame_tick, resampler_in_valid;
	logic        resampler_out_valid, proc_in_valid, vol_valid, out_valid;
	logic [19:0] serial_sample, spdif_sample, resampler_in_sample, q20;
	logic [19:0] resampler_out_sample, proc_in_sample, vol_sample;
	logic [19:0] ratio_value, out_sample;
	logic [16:0] input_rate_hz;
	logic [16:0] rates[8] = '{17'h0E5FA, 17'h0E5FB, 17'h0EEC5, 17'h0EEC6,
		17'h1347C, 17'h1347D, 17'h13C68, 17'h13C69};
	logic        antialias_enable, zero_detected, output_stage_reset;
	logic        truth_table_standard, spdif_digital_mode, multiplier_x8;
	logic        master_clock_from_crystal, master_clock_out_12m288;
	logic [7:0]  gain_reduction, gr;
	logic [31:0] rnd = 32'h5D5EF5E8;
	int          errors = 0, checks_done = 0, cycles = 0;

	audio_path_config_reg audio_path_config_reg_inst (.clk, .srst, .reg_wr,
		.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .serial_valid,
		.serial_sample, .spdif_valid, .spdif_sample, .frame_tick,
		.resampler_in_valid, .resampler_in_sample, .resampler_out_valid,
		.resampler_out_sample, .proc_in_valid, .proc_in_sample,
		.input_rate_hz, .antialias_enable, .vol_valid, .vol_sample,
		.ratio_value, .out_valid, .out_sample, .zero_detected,
		.gain_reduction, .output_stage_reset, .truth_table_standard,
		.spdif_digital_mode, .multiplier_x8, .master_clock_from_crystal,
		.master_clock_out_12m288);
	host_link_model host_link_model_inst (.clk, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .reg_ack);

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Code is {bit2, bit3}; output clips at positive full scale
	function automatic logic [19:0] exp_out(input logic [19:0] s,
		input logic [1:0] c);
		logic [21:0] p;
		p = s * (c == 2'b00 ? 22'h1 : (c == 2'b11 ? 22'h3 : 22'h2));
		return p > 22'h7FFFF ? 20'h7FFFF : p[19:0];
	endfunction
	// Code is {bit12, bit13}, window bounds inclusive
	function automatic logic aa_exp(input logic [1:0] c, input logic [16:0] r);
		if (c == 2'b11) return 1'b1;
		if (c == 2'b01) return r >= 17'h0E5FB && r <= 17'h0EEC5;
		if (c == 2'b10) return r >= 17'h1347D && r <= 17'h13C68;
		return 1'b0;
	endfunction
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] d);
		host_link_model_inst.access(1'b1, CFG_ADDR, d, q, ak);
		chk(ak, 1'b1);
	endtask
	task automatic rd(input logic [15:0] e);
		host_link_model_inst.access(1'b0, CFG_ADDR, 16'h0000, q, ak);
		chk({ak, q}, {1'b1, e});
	endtask
	task automatic levels(input logic [15:0] c);
		chk({output_stage_reset, truth_table_standard, spdif_digital_mode,
			multiplier_x8, master_clock_from_crystal, master_clock_out_12m288},
			{c[4], c[6], c[11], c[7], ~c[8], c[9]});
	endtask
	task automatic vol(input logic [19:0] s);
		@(negedge clk);
		vol_valid = 1'b1;
		vol_sample = s;
		@(negedge clk);
		vol_valid = 1'b0;
		vol_sample = ~s;
		chk(out_valid, 1'b1);
		q20 = out_sample;
	endtask
	// Source 0 serial, 1 S/PDIF, 2 resampler result, 3 frame tick
	task automatic route(input int src, input logic [19:0] s, input logic rs,
		input logic seen_exp);
		logic seen;
		logic [19:0] got;
		seen = 1'b0;
		got = 20'h00000;
		@(negedge clk);
		{serial_valid, spdif_valid} = {src == 0, src == 1};
		{resampler_out_valid, frame_tick} = {src == 2, src == 3};
		serial_sample = src == 1 ? ~s : s;
		spdif_sample = src == 1 ? s : ~s;
		resampler_out_sample = s;
		repeat (6) begin
			@(negedge clk);
			{serial_valid, spdif_valid, resampler_out_valid, frame_tick} = 4'h0;
			if ((rs ? resampler_in_valid : proc_in_valid) === 1'b1) begin
				seen = 1'b1;
				got = rs ? resampler_in_sample : proc_in_sample;
			end
		end
		chk({seen, got}, {seen_exp, seen_exp ? s : 20'h00000});
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run;
		end
	end

	initial begin
		{srst, serial_valid, spdif_valid, frame_tick} = 4'h8;
		{resampler_out_valid, vol_valid, input_rate_hz} = 19'h00000;
		{serial_sample, spdif_sample, resampler_out_sample} = 60'h0;
		{vol_sample, ratio_value} = 40'h0;
		repeat (12) @(negedge clk);
		srst = 1'b0;
		levels(CFG_RESET);
		rd(CFG_RESET & FC_READ_MASK);
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			v = host_link_model_inst.clock_bits({rnd[15:1], i[0]}, rnd[16]);
			wr(v);
			rd(v[0] ? v : v & FC_READ_MASK);
			levels(v);
		end
		host_link_model_inst.access(1'b1, CFG_ADDR + 7'h01, 16'hFFFF, q, ak);
		chk(ak, 1'b0);
		host_link_model_inst.access(1'b0, CFG_ADDR + 7'h01, 16'h0000, q, ak);
		chk({ak, q}, 17'h00000);
		rd(v);
		for (int c = 0; c < 4; c++) begin
			wr(16'h0001);
			wr(16'h0001 | {12'h000, c[0], c[1], 2'b00});
			rnd = lfsr(rnd);
			vol({4'h0, rnd[15:0]});
			chk(q20, exp_out({4'h0, rnd[15:0]}, c[1:0]));
			vol(20'h50000);
			chk(q20, exp_out(20'h50000, c[1:0]));
		end
		wr(16'h4001);
		ratio_value = rnd[19:0];
		vol(20'h00123);
		chk(q20, rnd[19:0]);
		wr(16'h0011);
		vol(20'h00123);
		chk(q20, 20'h00000);
		// Hold plus several release steps fit in one zero run
		wr(16'h0025);
		repeat (20) vol(20'h7FFFF);
		gr = gain_reduction;
		chk(gr !== 8'h00 && gr[1:0] === 2'b00, 1'b1);
		repeat (520) vol(20'h00000);
		chk(gain_reduction < gr, 1'b1);
		chk(zero_detected, 1'b1);
		wr(16'h0005);
		vol(20'h00000);
		chk(zero_detected, 1'b0);
		wr(16'h8001);
		route(0, rnd[19:0], 1'b0, 1'b1);
		wr(16'h8401);
		route(1, ~rnd[19:0], 1'b0, 1'b1);
		route(0, rnd[19:0], 1'b0, 1'b0);
		wr(16'h0001);
		route(0, rnd[19:0], 1'b1, 1'b1);
		route(2, 20'h13579, 1'b0, 1'b1);
		wr(16'h0401);
		route(1, ~rnd[19:0], 1'b1, 1'b1);
		wr(16'h8003);
		route(0, 20'h2468A, 1'b0, 1'b0);
		route(3, 20'h2468A, 1'b0, 1'b1);
		for (int c = 0; c < 4; c++) begin
			wr(16'h0001 | {2'b00, c[1], c[0], 12'h000});
			foreach (rates[k]) begin
				@(negedge clk);
				input_rate_hz = rates[k];
				repeat (3) @(negedge clk);
				chk(antialias_enable, aa_exp({c[0], c[1]}, rates[k]));
			end
		end
		// Second reset in mid-run must restore the defaults
		@(negedge clk);
		srst = 1'b1;
		@(negedge clk);
		srst = 1'b0;
		levels(CFG_RESET);
		rd(CFG_RESET & FC_READ_MASK);
		complete_run;
	end
endmodule // audio_path_config_reg_test
